//--- btg_defs.svh
// constants for the buzzer tone generator: offsets, field positions, counts
// assumes the includer compiles it once per unit; guard protects reuse
`ifndef BTG_DEFS_SVH
`define BTG_DEFS_SVH

// register indices; byte address is four times the index
`define BTG_IDX_CTRL     16'hff44
`define BTG_IDX_TONE     16'hff45
`define BTG_IDX_PIN      16'hff46

// control register bit positions
`define BTG_B_OUT_EN     0
`define BTG_B_ENV_EN     1
`define BTG_B_RESTART    2
`define BTG_B_STEP       3
`define BTG_B_LEN        4
`define BTG_B_TRIG       5
`define BTG_B_STOP       6

// tone register field positions (3 bits each)
`define BTG_F_FREQ_LSB   0
`define BTG_F_LEVEL_LSB  4

// pin data register bit positions
`define BTG_B_PIN_A      0
`define BTG_B_PIN_B      1

// reset values
`define BTG_RST_FREQ     3'h0
`define BTG_RST_LEVEL    3'h0

// oscillator and timebase
`define BTG_OSC_HZ       32768
`define BTG_TB_HZ        256
`define BTG_TB_DIV       (`BTG_OSC_HZ / `BTG_TB_HZ)

// times in microseconds and their counts of timebase ticks
`define BTG_STEP_LONG_US  125000
`define BTG_STEP_SHORT_US 62500
`define BTG_OS_LONG_US    125000
`define BTG_OS_SHORT_US   31250
`define BTG_US_TO_TICKS(t) (((t) * `BTG_TB_HZ) / 1000000)

// tone shape, in units of the divider input
`define BTG_PERIOD_BASE  16
`define BTG_PERIOD_STEP  4
`define BTG_HI_NARROW    8
`define BTG_HI_WIDE      12
`define BTG_LEVEL_LAST   3'h7

// bus answers
`define BTG_RESP_OKAY    2'h0
`define BTG_RESP_SLVERR  2'h2

`endif

//--- btg_pkg.sv
// types shared by the buzzer tone generator modules
// assumes btg_defs.svh holds all numeric constants
package btg_pkg;

    // one-shot sequencer, one-hot
    typedef enum logic [2:0] {
        BTG_OS_IDLE = 3'b001,  // ready
        BTG_OS_PEND = 3'b010,  // waiting for timebase edge
        BTG_OS_RUN  = 3'b100   // tone sounding
    } btg_os_t;

    // settings handed to the divider
    typedef struct packed {
        logic [2:0] freq;      // tone select
        logic [2:0] level;     // effective duty level
        logic       tick_fast; // both oscillator edges
        logic       tick_slow; // rising oscillator edge
    } btg_tone_cfg_t;

    // divider state
    typedef struct packed {
        logic [4:0] cnt;       // position in tone period
        logic       tone;      // raw tone level
    } btg_div_st_t;

    // top state
    typedef struct packed {
        logic        osc_s1;   // sync stage 1
        logic        osc_s2;   // sync stage 2
        logic        osc_s3;   // edge history
        logic [6:0]  pre;      // timebase prescaler
        logic        out_en;   // continuous tone on
        logic        env_en;   // envelope on
        logic        step_sel; // envelope step time
        logic        len_sel;  // one-shot length
        logic [2:0]  freq;     // tone select
        logic [2:0]  level;    // duty select
        logic        pin_a_dat;// general data bit, pin a
        logic        pin_b_dat;// general data bit, pin b
        logic [2:0]  stage;    // envelope stage
        logic [5:0]  step_cnt; // ticks in stage
        btg_os_t     os;       // one-shot state
        logic [5:0]  os_cnt;   // ticks of one-shot
        logic        pin_a;    // pin a driver
        logic        pin_b;    // pin b driver
        logic        aw_got;   // address held
        logic        w_got;    // data held
        logic [15:0] aw_idx;   // held word index
        logic [31:0] wdata;    // held data
        logic [3:0]  wstrb;    // held strobes
        logic        awready;  // bus outputs
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } btg_st_t;

endpackage

//--- btg_tone_div.sv
// tone divider: period and high time from frequency and level select
// assumes tick inputs are single-cycle pulses on clk
`timescale 1ns/10ps
`include "btg_defs.svh"

module btg_tone_div
    import btg_pkg::*;
(
    input  wire logic          clk,    // system clock
    input  wire logic          arst_n, // async reset, low
    input  wire btg_tone_cfg_t cfg,    // select and ticks
    output logic               tone    // tone level, registered
);

    btg_div_st_t s_r;   // state
    btg_div_st_t s_nxt; // next state

    // period in units: 16, 20, 24 or 28 by low freq bits
    function automatic logic [4:0] period_of(input logic [2:0] f);
        period_of = 5'(`BTG_PERIOD_BASE + `BTG_PERIOD_STEP * f[1:0]);
    endfunction

    // level zero widest
    // high units: base of group minus level
    function automatic logic [4:0] high_of(input logic [2:0] f, input logic [2:0] l);
        high_of = 5'((f[1] ? `BTG_HI_WIDE : `BTG_HI_NARROW) - l);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic adv;
        logic [4:0] nc;
        adv   = 1'b0;
        nc    = 5'h0;
        s_nxt = s_r;
        // upper group counts at half rate
        adv = cfg.freq[2] ? cfg.tick_slow : cfg.tick_fast;
        if (adv) begin
            // >= also recovers when a freq change shortens the period
            nc = (s_r.cnt >= period_of(cfg.freq) - 5'h1) ? 5'h0 : s_r.cnt + 5'h1;
            s_nxt.cnt = nc;
            // high for first units of period
            s_nxt.tone = (nc < high_of(cfg.freq, cfg.level));
        end
    end

    // registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tone = s_r.tone;

endmodule // btg_tone_div

//--- btg_top.sv
// buzzer tone generator: axi4-lite registers, envelope, one-shot, pins
// assumes low_speed_oscillator is asynchronous to clk and far slower
`timescale 1ns/10ps
`include "btg_defs.svh"

module btg_top
    import btg_pkg::*;
#(
    parameter bit INV_PIN_EN = 1'b1 // second pin carries inverse tone
)(
    input  wire logic        clk,                  // 100 MHz clock
    input  wire logic        arst_n,               // async reset, low
    input  wire logic        low_speed_oscillator, // 32.768 kHz, async
    input  wire logic [31:0] s_axi_awaddr,         // write address
    input  wire logic        s_axi_awvalid,        // write address valid
    output logic             s_axi_awready,        // write address ready
    input  wire logic [31:0] s_axi_wdata,          // write data
    input  wire logic [3:0]  s_axi_wstrb,          // byte enables
    input  wire logic        s_axi_wvalid,         // write data valid
    output logic             s_axi_wready,         // write data ready
    output logic [1:0]       s_axi_bresp,          // write answer
    output logic             s_axi_bvalid,         // write answer valid
    input  wire logic        s_axi_bready,         // write answer taken
    input  wire logic [31:0] s_axi_araddr,         // read address
    input  wire logic        s_axi_arvalid,        // read address valid
    output logic             s_axi_arready,        // read address ready
    output logic [31:0]      s_axi_rdata,          // read data
    output logic [1:0]       s_axi_rresp,          // read answer
    output logic             s_axi_rvalid,         // read data valid
    input  wire logic        s_axi_rready,         // read data taken
    output logic             tone_pin_true,        // first port pin
    output logic             tone_pin_inverted     // second port pin
);

    localparam logic [5:0] STEP_LONG  = 6'(`BTG_US_TO_TICKS(`BTG_STEP_LONG_US));
    localparam logic [5:0] STEP_SHORT = 6'(`BTG_US_TO_TICKS(`BTG_STEP_SHORT_US));
    localparam logic [5:0] OS_LONG    = 6'(`BTG_US_TO_TICKS(`BTG_OS_LONG_US));
    localparam logic [5:0] OS_SHORT   = 6'(`BTG_US_TO_TICKS(`BTG_OS_SHORT_US));
    localparam logic [6:0] TB_LAST    = 7'(`BTG_TB_DIV - 1);

    btg_st_t       s_r;        // state
    btg_st_t       s_nxt;      // next state
    btg_tone_cfg_t cfg;        // divider settings
    logic          tone_signal;// raw tone from divider
    logic          tick_fast;  // any oscillator edge
    logic          tick_slow;  // rising oscillator edge
    logic          tb_tick;    // 256 Hz timebase edge
    logic          live;       // tone is to be driven
    logic          wr_do;      // write executes this cycle
    logic          wr_ctrl;    // write to control register
    logic [7:0]    wb;         // low byte of held write

    ////////////////////////////////////////////////////////////////////////
    // oscillator edges and timebase
    // s2 against s3 only; s1 feeds s2 alone
    always_comb begin
        tick_fast = s_r.osc_s2 ^ s_r.osc_s3;
        tick_slow = s_r.osc_s2 & ~s_r.osc_s3;
        tb_tick   = tick_slow && (s_r.pre == TB_LAST);
    end

    // write decode, shared by state update and checks
    always_comb begin
        wr_do   = s_r.aw_got && s_r.w_got && !s_r.bvalid;
        wr_ctrl = wr_do && (s_r.aw_idx == `BTG_IDX_CTRL) && s_r.wstrb[0];
        wb      = s_r.wdata[7:0];
    end

    // tone drive: continuous or one-shot sounding
    always_comb begin
        live = s_r.out_en || (s_r.os == BTG_OS_RUN);
    end

    // divider settings
    always_comb begin
        cfg.freq      = s_r.freq;
        cfg.level     = (s_r.env_en && s_r.out_en) ? s_r.stage : s_r.level;
        cfg.tick_fast = tick_fast;
        cfg.tick_slow = tick_slow;
    end

    // divider free-runs; switching truncates at most half a period
    // no alignment to writes
    btg_tone_div u_div (
        .clk    (clk),
        .arst_n (arst_n),
        .cfg    (cfg),
        .tone   (tone_signal)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic [5:0] step_len;
        logic [5:0] os_len;
        logic       rd_hit;
        logic [15:0] ar_idx;
        step_len = 6'h0;
        os_len   = 6'h0;
        rd_hit   = 1'b0;
        ar_idx   = 16'h0;
        s_nxt    = s_r;

        // synchroniser and prescaler
        s_nxt.osc_s1 = low_speed_oscillator;
        s_nxt.osc_s2 = s_r.osc_s1;
        s_nxt.osc_s3 = s_r.osc_s2;
        if (tick_slow) begin
            s_nxt.pre = (s_r.pre == TB_LAST) ? 7'h0 : s_r.pre + 7'h1;
        end

        step_len = s_r.step_sel ? STEP_LONG : STEP_SHORT;
        os_len   = s_r.len_sel ? OS_LONG : OS_SHORT;

        // envelope stepping
        if (!s_r.out_en) begin
            // restart from level 0 on next enable
            s_nxt.stage    = 3'h0;
            s_nxt.step_cnt = 6'h0;
        end else if (s_r.env_en && tb_tick) begin
            if (s_r.step_cnt == step_len - 6'h1) begin
                s_nxt.step_cnt = 6'h0;
                if (s_r.stage != `BTG_LEVEL_LAST) begin
                    s_nxt.stage = s_r.stage + 3'h1;
                end
            end else begin
                s_nxt.step_cnt = s_r.step_cnt + 6'h1;
            end
        end

        // one-shot sequencer
        case (s_r.os)
            BTG_OS_IDLE: begin
                s_nxt.os_cnt = 6'h0;
            end
            BTG_OS_PEND: begin
                if (tb_tick) begin
                    s_nxt.os     = BTG_OS_RUN;
                    s_nxt.os_cnt = 6'h0;
                end
            end
            BTG_OS_RUN: begin
                if (tb_tick) begin
                    if (s_r.os_cnt == os_len - 6'h1) begin
                        s_nxt.os = BTG_OS_IDLE;
                    end else begin
                        s_nxt.os_cnt = s_r.os_cnt + 6'h1;
                    end
                end
            end
            default: begin
                s_nxt.os = BTG_OS_IDLE;
            end
        endcase

        // register writes
        if (wr_do) begin
            if (wr_ctrl) begin
                s_nxt.out_en   = wb[`BTG_B_OUT_EN];
                s_nxt.env_en   = wb[`BTG_B_ENV_EN];
                s_nxt.step_sel = wb[`BTG_B_STEP];
                s_nxt.len_sel  = wb[`BTG_B_LEN];
                if (wb[`BTG_B_RESTART]) begin
                    s_nxt.stage    = 3'h0;
                    s_nxt.step_cnt = 6'h0;
                end
                if (wb[`BTG_B_TRIG] && !s_r.out_en && s_r.os == BTG_OS_IDLE) begin
                    s_nxt.os     = BTG_OS_PEND;
                    s_nxt.env_en = 1'b0;
                end
                if (wb[`BTG_B_STOP]) begin
                    s_nxt.os = BTG_OS_IDLE;
                end
            end else if (s_r.aw_idx == `BTG_IDX_TONE && s_r.wstrb[0]) begin
                s_nxt.freq  = wb[`BTG_F_FREQ_LSB +: 3];
                s_nxt.level = wb[`BTG_F_LEVEL_LSB +: 3];
            end else if (s_r.aw_idx == `BTG_IDX_PIN && s_r.wstrb[0]) begin
                s_nxt.pin_a_dat = wb[`BTG_B_PIN_A];
                s_nxt.pin_b_dat = wb[`BTG_B_PIN_B];
            end
        end

        // pin drivers
        // idle pins steady
        // pin a data bit ors onto the tone
        s_nxt.pin_a = (live & tone_signal) | s_r.pin_a_dat;
        if (INV_PIN_EN) begin
            // pin b data bit unused here
            s_nxt.pin_b = ~(live & tone_signal);
        end else begin
            s_nxt.pin_b = s_r.pin_b_dat;
        end

        // write channel
        if (s_r.awready && s_axi_awvalid) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.aw_idx = s_axi_awaddr[17:2];
        end
        if (s_r.wready && s_axi_wvalid) begin
            s_nxt.w_got = 1'b1;
            s_nxt.wdata = s_axi_wdata;
            s_nxt.wstrb = s_axi_wstrb;
        end
        if (wr_do) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got  = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp  = (s_r.aw_idx == `BTG_IDX_CTRL || s_r.aw_idx == `BTG_IDX_TONE
                            || s_r.aw_idx == `BTG_IDX_PIN) ? `BTG_RESP_OKAY : `BTG_RESP_SLVERR;
        end else if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end
        // each ready held low while its own beat is held or the answer is pending
        s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid && !(s_r.awready && s_axi_awvalid);
        s_nxt.wready  = !s_nxt.w_got && !s_nxt.bvalid && !(s_r.wready && s_axi_wvalid);

        // read channel
        if (s_r.arready && s_axi_arvalid) begin
            ar_idx       = s_axi_araddr[17:2];
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata  = 32'h0;
            rd_hit       = 1'b1;
            case (ar_idx)
                `BTG_IDX_CTRL: begin
                    s_nxt.rdata[`BTG_B_OUT_EN] = s_r.out_en;
                    s_nxt.rdata[`BTG_B_ENV_EN] = s_r.env_en;
                    s_nxt.rdata[`BTG_B_STEP]   = s_r.step_sel;
                    s_nxt.rdata[`BTG_B_LEN]    = s_r.len_sel;
                    s_nxt.rdata[`BTG_B_TRIG]   = (s_r.os != BTG_OS_IDLE);
                end
                `BTG_IDX_TONE: begin
                    s_nxt.rdata[`BTG_F_FREQ_LSB +: 3]  = s_r.freq;
                    s_nxt.rdata[`BTG_F_LEVEL_LSB +: 3] = s_r.level;
                end
                `BTG_IDX_PIN: begin
                    s_nxt.rdata[`BTG_B_PIN_A] = s_r.pin_a_dat;
                    s_nxt.rdata[`BTG_B_PIN_B] = s_r.pin_b_dat;
                end
                default: begin
                    rd_hit = 1'b0;
                end
            endcase
            s_nxt.rresp = rd_hit ? `BTG_RESP_OKAY : `BTG_RESP_SLVERR;
        end else if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end
        s_nxt.arready = !s_nxt.rvalid && !(s_r.arready && s_axi_arvalid);
    end

    ////////////////////////////////////////////////////////////////////////
    // registers; idle pins start low and high
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r       <= '0;
            s_r.os    <= BTG_OS_IDLE;
            s_r.freq  <= `BTG_RST_FREQ;
            s_r.level <= `BTG_RST_LEVEL;
            s_r.pin_b <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from flops
    always_comb begin
        s_axi_awready     = s_r.awready;
        s_axi_wready      = s_r.wready;
        s_axi_bvalid      = s_r.bvalid;
        s_axi_bresp       = s_r.bresp;
        s_axi_arready     = s_r.arready;
        s_axi_rvalid      = s_r.rvalid;
        s_axi_rresp       = s_r.rresp;
        s_axi_rdata       = s_r.rdata;
        tone_pin_true     = s_r.pin_a;
        tone_pin_inverted = s_r.pin_b;
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_idle_pins;
        !live && !s_r.pin_a_dat |=> !tone_pin_true && (tone_pin_inverted || !INV_PIN_EN);
    endproperty
    a_idle_pins: assert property (p_idle_pins) else $error("idle pins not steady");

    property p_busy_read;
        wr_ctrl && wb[`BTG_B_TRIG] && !wb[`BTG_B_STOP] && !s_r.out_en |=> s_r.os != BTG_OS_IDLE;
    endproperty
    a_busy_read: assert property (p_busy_read) else $error("trigger did not set busy");

    property p_force_stop;
        wr_ctrl && wb[`BTG_B_STOP] |=> s_r.os == BTG_OS_IDLE ##1 !tone_pin_true || s_r.pin_a_dat || live;
    endproperty
    a_force_stop: assert property (p_force_stop) else $error("force stop did not end one-shot");

    property p_trig_env;
        wr_ctrl && wb[`BTG_B_TRIG] && !s_r.out_en && s_r.os == BTG_OS_IDLE |=> !s_r.env_en;
    endproperty
    a_trig_env: assert property (p_trig_env) else $error("envelope left on by trigger");

    property p_trig_ignored;
        wr_ctrl && wb[`BTG_B_TRIG] && s_r.out_en && s_r.os == BTG_OS_IDLE |=> s_r.os == BTG_OS_IDLE;
    endproperty
    a_trig_ignored: assert property (p_trig_ignored) else $error("trigger taken during tone");

    property p_restart;
        wr_ctrl && wb[`BTG_B_RESTART] |=> s_r.stage == 3'h0 && s_r.step_cnt == 6'h0;
    endproperty
    a_restart: assert property (p_restart) else $error("restart missed");

    property p_hold_last;
        s_r.stage == `BTG_LEVEL_LAST && s_r.out_en && !(wr_ctrl && wb[`BTG_B_RESTART])
            && !(wr_ctrl && !wb[`BTG_B_OUT_EN]) |=> s_r.stage == `BTG_LEVEL_LAST;
    endproperty
    a_hold_last: assert property (p_hold_last) else $error("stage left last level");

    property p_pend_wait;
        s_r.os == BTG_OS_PEND && !tb_tick && !wr_ctrl |=> s_r.os == BTG_OS_PEND;
    endproperty
    a_pend_wait: assert property (p_pend_wait) else $error("one-shot started off timebase");

    property p_run_stop;
        s_r.os == BTG_OS_RUN && $fell(s_nxt.os == BTG_OS_RUN) && !wr_ctrl |-> tb_tick;
    endproperty
    a_run_stop: assert property (p_run_stop) else $error("one-shot ended off timebase");

    c_oneshot_done: cover property (s_r.os == BTG_OS_RUN ##1 s_r.os == BTG_OS_IDLE);
    c_env_last: cover property (s_r.env_en && s_r.stage == `BTG_LEVEL_LAST);
    c_forced: cover property (s_r.os == BTG_OS_RUN && wr_ctrl && wb[`BTG_B_STOP]);

endmodule // btg_top

//--- btg_piezo.sv
// piezo model: measures the pulses that reach the buzzer
// assumes the pins are steady between bench clock edges
`timescale 1ns/10ps

module btg_piezo (
    input  wire logic clk,    // bench clock
    input  wire logic drv_a,  // true pin
    output int        hi_len, // last high time, clocks
    output int        per_len // last period, clocks
);
    int   hc;  // high clocks so far
    int   pc;  // clocks since rise
    logic a_d; // previous level

    // duty seen as high time over period
    always @(posedge clk) begin
        a_d <= drv_a;
        pc  <= (drv_a && !a_d) ? 1 : pc + 1;
        hc  <= (drv_a && !a_d) ? 1 : hc + drv_a;
        if (drv_a && !a_d) per_len <= pc;
        if (!drv_a && a_d) hi_len <= hc;
    end
endmodule // btg_piezo

//--- tb.sv
// bench: bus tasks, random tones, one-shot and stop cases
// assumes the oscillator may run far faster than real life
`timescale 1ns/10ps
`include "btg_defs.svh"

module tb;
    logic        clk = 0, arst_n = 0, osc = 0;     // clocks, reset
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0; // bus payload
    logic [3:0]  wstrb = 0;                         // byte enables
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid, pin_t, pin_i;
    logic [1:0]  bresp, rr;                         // answers
    logic [31:0] rdata, rd;                         // read data
    int          failures = 0, checked = 0, hi_len, per_len, n, f, l;

    always #5 clk = ~clk;
    // oscillator at 10 clocks a cycle, so long timers fit the run
    always #50 osc = ~osc;

    btg_top i_dut (.clk(clk), .arst_n(arst_n), .low_speed_oscillator(osc),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .tone_pin_true(pin_t), .tone_pin_inverted(pin_i));
    btg_piezo i_pz (.clk(clk), .drv_a(pin_t), .hi_len(hi_len), .per_len(per_len));

    //////////////////////////////
    // expected pulse sizes in clocks; unit is 5 or 10
    function automatic int exp_hi(input logic [2:0] fq, input logic [2:0] lv);
        return ((fq[1] ? 12 : 8) - lv) * (fq[2] ? 10 : 5);
    endfunction
    function automatic int exp_per(input logic [2:0] fq);
        return (16 + 4 * fq[1:0]) * (fq[2] ? 10 : 5);
    endfunction

    task chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task close_out;
        $display("failures=%0d checked=%0d", failures, checked);
        if (failures == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // a hung handshake counts as a mismatch
    task tmo;
        failures++;
        close_out;
    endtask

    // write: both channels offered at once, bready held till bvalid
    task wr(input logic [15:0] idx, input logic [7:0] d);
        @(posedge clk);
        awaddr  <= {14'h0, idx, 2'b00};
        wdata   <= {24'h0, d};
        wstrb   <= 4'hf;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 99);
        bready <= 1'b0;
        if (n >= 99) tmo;
    endtask

    // read: data and answer land in rd and rr
    task rdr(input logic [15:0] idx);
        @(posedge clk);
        araddr  <= {14'h0, idx, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 99);
        rd = rdata;
        rready <= 1'b0;
        if (n >= 99) tmo;
    endtask

    //////////////////////////////
    initial begin
        n = $urandom(47);
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk(pin_t ^ pin_i, 1);
        rdr(`BTG_IDX_TONE);
        chk(rd, 0);
        chk(rr, `BTG_RESP_OKAY);
        rdr(16'h0010);
        chk(rr, `BTG_RESP_SLVERR);
        wr(16'h0010, 8'h00);
        chk(bresp, `BTG_RESP_SLVERR);
        // pin b data low: a pin that followed it would show low
        wr(`BTG_IDX_PIN, 8'h01);
        chk(bresp, `BTG_RESP_OKAY);
        repeat (2) @(posedge clk);
        chk(pin_i, 1);
        wr(`BTG_IDX_PIN, 8'h00);
        // first pass is the slowest tone at the top level
        for (int k = 0; k < 4; k++) begin
            f = k ? $urandom % 8 : 7;
            l = k ? $urandom % 8 : 7;
            wr(`BTG_IDX_TONE, {1'b0, l[2:0], 1'b0, f[2:0]});
            wr(`BTG_IDX_CTRL, 8'h01);
            repeat (800) @(posedge clk);
            chk(hi_len, exp_hi(f[2:0], l[2:0]));
            chk(per_len, exp_per(f[2:0]));
            chk(pin_t ^ pin_i, 1);
        end
        // envelope starts at level 0 whatever the field says
        wr(`BTG_IDX_TONE, 8'h70);
        wr(`BTG_IDX_CTRL, 8'h00);
        wr(`BTG_IDX_CTRL, 8'h03);
        repeat (800) @(posedge clk);
        chk(hi_len, exp_hi(3'h0, 3'h0));
        // one short step is 16 ticks of 1280 clocks here
        repeat (16 * 1280) @(posedge clk);
        chk(hi_len, exp_hi(3'h0, 3'h1));
        wr(`BTG_IDX_CTRL, 8'h07);
        repeat (800) @(posedge clk);
        chk(hi_len, exp_hi(3'h0, 3'h0));
        wr(`BTG_IDX_CTRL, 8'h00);
        repeat (2) @(posedge clk);
        chk(pin_t, 0);
        wr(`BTG_IDX_CTRL, 8'h22);
        rdr(`BTG_IDX_CTRL);
        chk(rd, 8'h20);
        f = 0;
        do begin
            rdr(`BTG_IDX_CTRL);
            f++;
        end while (rd[5] === 1'b1 && f < 4000);
        chk(rd, 0);
        if (f >= 4000) tmo;
        // busy 8 ticks plus wait for first tick; 3 clocks a poll
        chk((f * 3 > 8 * 1280 - 40) && (f * 3 < 9 * 1280 + 40), 1);
        wr(`BTG_IDX_CTRL, 8'h30);
        wr(`BTG_IDX_CTRL, 8'h50);
        rdr(`BTG_IDX_CTRL);
        chk(rd, 8'h10);
        wr(`BTG_IDX_CTRL, 8'h01);
        wr(`BTG_IDX_CTRL, 8'h21);
        rdr(`BTG_IDX_CTRL);
        chk(rd, 8'h01);
        close_out;
    end
endmodule // tb
